// ---- logic/fpd_fan_duty.sv ----
// Fan drive duty selector with its register file and identification codes.
// Assumes a register port already framed by an upstream serial slave and a
// digitised temperature voltage in millivolts, both synchronous to clk_i.

// What this block does
// - A 4-bit writable duty register sets the fan drive duty when register control is chosen.
// - The duty register spans 30% to 100% of the period in steps of 4.67%.
// - Codes decode in ascending order, 0 giving 30% and 15 giving 100%.
// - The duty register resets to code 2 and is used when the temperature input is open.
// - In temperature mode 1.62 V to 2.6 V maps linearly onto 30% to 100% duty.
// - The duty source select bit picks the register when 1 and, unless the input is open, the temperature input when 0, resetting to 0.
// - The open flag is caught once after power-up, 1 when nothing is connected.
// - An 8-bit read-only maker code is returned and writes leave it alone.
// - A 2-bit read-only variant code tells which product variant is present.
module fpd_fan_duty
    import fpd_pkg::*;
#(
    parameter int unsigned PERIOD       = PERIOD_CYC,
    // Value arbitrary.
    parameter logic [7:0]  MAKER_CODE   = 8'h3C,
    // Value arbitrary.
    parameter logic [1:0]  VARIANT_CODE = 2'h2
)(
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    input  wire fpd_reg_req_t     reg_req_i,
    output logic [7:0]            reg_rdata_o,
    input  wire logic [MV_W-1:0]  temp_mv_i,
    input  wire logic             temp_open_i,
    output logic                  fan_drive_o
);

    if (PERIOD < 10 || PERIOD > 32'h7FFF_FFFF)
    begin : g_period_check
        $error("PERIOD out of range");
    end

    fpd_state_t s;
    fpd_state_t next_s;

    function automatic logic [CNT_W-1:0] reg_on(input logic [3:0] code);
        logic [63:0] num;
        num = 64'(PERIOD) * (64'(DUTY_BASE) + 64'(DUTY_STEP) * 64'(code));
        return CNT_W'(num / 64'(DUTY_DEN));
    endfunction

    function automatic logic [CNT_W-1:0] temp_on(input logic [MV_W-1:0] mv);
        logic [63:0] d;
        logic [63:0] span;
        d    = 64'(mv);
        span = 64'(VIN_HI_MV - VIN_LO_MV);
        if (d < 64'(VIN_LO_MV))
            d = 64'(VIN_LO_MV);
        if (d > 64'(VIN_HI_MV))
            d = 64'(VIN_HI_MV);
        d = 64'(MIN_DUTY_TEN) * span + 64'(SPAN_TEN) * (d - 64'(VIN_LO_MV));
        return CNT_W'((64'(PERIOD) * d) / (64'(10) * span));
    endfunction

    logic [CNT_W-1:0] target_on;
    logic [7:0]       read_val;

    always_comb
    begin
        if (s.src_reg || s.open_flag)
            target_on = reg_on(s.duty);
        else
            target_on = temp_on(temp_mv_i);

        unique case (reg_req_i.sel)
            SEL_CONFIG:  read_val = 8'(s.src_reg) << SRC_SEL_BIT;
            SEL_STATUS:  read_val = 8'(s.open_flag) << OPEN_BIT;
            SEL_DUTY:    read_val = {4'h0, s.duty};
            SEL_MAKER:   read_val = MAKER_CODE;
            SEL_VARIANT: read_val = {6'h00, VARIANT_CODE};
            default:     read_val = 8'h00;
        endcase
    end

    always_comb
    begin
        next_s = s;
        if (!s.strapped)
        begin
            next_s.open_flag = temp_open_i;
            next_s.strapped  = 1'b1;
        end
        if (reg_req_i.wr && reg_req_i.sel == SEL_DUTY)
            next_s.duty = reg_req_i.wdata[3:0];
        if (reg_req_i.wr && reg_req_i.sel == SEL_CONFIG)
            next_s.src_reg = reg_req_i.wdata[SRC_SEL_BIT];
        if (reg_req_i.rd)
            next_s.rdata = read_val;
        // New duty takes effect only at a period boundary, so no runt pulses.
        if (s.cnt == CNT_W'(PERIOD - 1))
        begin
            next_s.cnt    = '0;
            next_s.on_cnt = target_on;
        end
        else
            next_s.cnt = s.cnt + CNT_W'(1);
        next_s.drive = next_s.cnt < next_s.on_cnt;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            s           <= '0;
            s.duty      <= DUTY_RST;
            s.open_flag <= 1'b1;
        end
        else
            s <= next_s;
    end

    assign reg_rdata_o = s.rdata;
    assign fan_drive_o = s.drive;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    logic wrap;
    assign wrap = s.cnt == CNT_W'(PERIOD - 1);

    property p_duty_write;
        reg_req_i.wr && reg_req_i.sel == SEL_DUTY
            |=> s.duty == $past(reg_req_i.wdata[3:0]);
    endproperty
    a_duty_write: assert property (p_duty_write)
        else $error("duty register did not take write");

    property p_duty_hold;
        !(reg_req_i.wr && reg_req_i.sel == SEL_DUTY) |=> $stable(s.duty);
    endproperty
    a_duty_hold: assert property (p_duty_hold)
        else $error("duty register changed without a write");

    property p_reg_step;
        wrap && (s.src_reg || s.open_flag) |=>
            64'(s.on_cnt) * 64'(DUTY_DEN) <= 64'(PERIOD)
                * (64'(DUTY_BASE) + 64'(DUTY_STEP) * 64'($past(s.duty)))
            && 64'(s.on_cnt + CNT_W'(1)) * 64'(DUTY_DEN) > 64'(PERIOD)
                * (64'(DUTY_BASE) + 64'(DUTY_STEP) * 64'($past(s.duty)));
    endproperty
    a_reg_step: assert property (p_reg_step)
        else $error("register duty off its step");

    property p_full_code;
        wrap && s.src_reg && s.duty == 4'hF |=> s.on_cnt == CNT_W'(PERIOD);
    endproperty
    a_full_code: assert property (p_full_code)
        else $error("code fifteen not full duty");

    property p_duty_reset;
        $rose(s.strapped) && !$past(reg_req_i.wr && reg_req_i.sel == SEL_DUTY)
            |-> s.duty == DUTY_RST;
    endproperty
    a_duty_reset: assert property (p_duty_reset)
        else $error("duty register reset value wrong");

    property p_temp_ends;
        wrap && !s.src_reg && !s.open_flag |=>
            ($past(temp_mv_i) < MV_W'(VIN_HI_MV)
                || s.on_cnt == CNT_W'(PERIOD))
            && ($past(temp_mv_i) > MV_W'(VIN_LO_MV)
                || s.on_cnt == CNT_W'(64'(PERIOD) * 64'(MIN_DUTY_TEN)
                    / 64'(10)));
    endproperty
    a_temp_ends: assert property (p_temp_ends)
        else $error("temperature window ends wrong");

    property p_src_write;
        reg_req_i.wr && reg_req_i.sel == SEL_CONFIG
            |=> s.src_reg == $past(reg_req_i.wdata[SRC_SEL_BIT]);
    endproperty
    a_src_write: assert property (p_src_write)
        else $error("source select did not take write");

    property p_src_hold;
        !(reg_req_i.wr && reg_req_i.sel == SEL_CONFIG) |=> $stable(s.src_reg);
    endproperty
    a_src_hold: assert property (p_src_hold)
        else $error("source select changed without a write");

    property p_open_catch;
        $rose(s.strapped) |-> s.open_flag == $past(temp_open_i)
            ##1 $stable(s.open_flag)[*3];
    endproperty
    a_open_catch: assert property (p_open_catch)
        else $error("open flag not caught at power-up");

    property p_open_hold;
        s.strapped |=> $stable(s.open_flag);
    endproperty
    a_open_hold: assert property (p_open_hold)
        else $error("open flag changed after power-up");

    property p_maker;
        reg_req_i.rd && reg_req_i.sel == SEL_MAKER |=> reg_rdata_o == MAKER_CODE;
    endproperty
    a_maker: assert property (p_maker)
        else $error("maker code read wrong");

    property p_variant;
        reg_req_i.rd && reg_req_i.sel == SEL_VARIANT
            |=> reg_rdata_o == {6'h00, VARIANT_CODE};
    endproperty
    a_variant: assert property (p_variant)
        else $error("variant code read wrong");

    property p_drive_shape;
        (s.cnt == '0 && s.on_cnt != '0 |-> fan_drive_o)
        and (wrap && s.on_cnt < CNT_W'(PERIOD) |-> !fan_drive_o);
    endproperty
    a_drive_shape: assert property (p_drive_shape)
        else $error("drive period shape wrong");

    c_full:  cover property (wrap && s.src_reg && s.duty == 4'hF);
    c_temp:  cover property (wrap && !s.src_reg && !s.open_flag);
    c_open:  cover property (wrap && !s.src_reg && s.open_flag);
    c_reg:   cover property (wrap && s.src_reg && !s.open_flag);

endmodule : fpd_fan_duty

// ---- logic/fpd_pkg.sv ----
// Constants, register selects and carrier types of the fan duty selector.
// Assumes one 125 MHz clock shared by every user of the package.
package fpd_pkg;

    localparam int unsigned CLK_HZ       = 125_000_000;
    localparam int unsigned PWM_FREQ_HZ  = 30;
    // Drive period in clock cycles, rounded down.
    localparam int unsigned PERIOD_CYC   = CLK_HZ / PWM_FREQ_HZ;
    localparam int unsigned CNT_W        = 32;

    // Duty in thirds of a percent: code n gives (90 + 14 n)/300.
    localparam int unsigned DUTY_BASE    = 90;
    localparam int unsigned DUTY_STEP    = 14;
    localparam int unsigned DUTY_DEN     = 300;

    // Temperature voltage window in millivolts and the duty it spans.
    localparam int unsigned VIN_LO_MV    = 1620;
    localparam int unsigned VIN_HI_MV    = 2600;
    localparam int unsigned MIN_DUTY_TEN = 3;
    localparam int unsigned SPAN_TEN     = 7;
    localparam int unsigned MV_W         = 12;

    localparam logic [2:0] SEL_CONFIG    = 3'h1;
    localparam logic [2:0] SEL_STATUS    = 3'h2;
    localparam logic [2:0] SEL_DUTY      = 3'h3;
    localparam logic [2:0] SEL_MAKER     = 3'h4;
    localparam logic [2:0] SEL_VARIANT   = 3'h5;

    localparam int unsigned SRC_SEL_BIT  = 5;
    localparam int unsigned OPEN_BIT     = 2;
    localparam logic [3:0] DUTY_RST      = 4'h2;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] sel;
        logic [7:0] wdata;
    } fpd_reg_req_t;

    typedef struct packed {
        logic [3:0]       duty;
        logic             src_reg;
        logic             open_flag;
        logic             strapped;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] on_cnt;
        logic             drive;
        logic [7:0]       rdata;
    } fpd_state_t;

endpackage : fpd_pkg

// ---- verification/fpd_fan_model.sv ----
// Partner model of the fan drive transistor: counts cycles the drive is on.
// Assumes the drive is sampled on the bench clock and cleared by the bench.
module fpd_fan_model (
    input  wire logic        clk_i,
    input  wire logic        clr_i,
    input  wire logic        fan_drive_i,
    output logic [15:0]      on_cyc_o
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk_i)
    begin
        if (clr_i)
        begin
            on_cyc_o <= 16'h0000;
        end
        else if (fan_drive_i)
        begin
            on_cyc_o <= on_cyc_o + 16'h0001;
        end
    end
endmodule // fpd_fan_model

// ---- verification/tb_fpd_fan_duty.sv ----
// Self-checking bench of the fan duty selector.
// Assumes a short drive period so that every duty code can be measured.
module tb_fpd_fan_duty;
    import fpd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned P = 30;
    logic            clk_i;
    logic            arst_n_i;
    logic            temp_open_i;
    logic            clr;
    logic            drive;
    fpd_reg_req_t    req;
    logic [MV_W-1:0] mv;
    logic [7:0]      rdata;
    logic [15:0]     on_cyc;
    int              errors;
    int              n_checks;
    int unsigned     mvs[5] = '{1620, 2600, 2110, 1000, 4000};

    // Identification values are arbitrary.
    fpd_fan_duty #(.PERIOD(P), .MAKER_CODE(8'hA5), .VARIANT_CODE(2'h3)) uut (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_req_i(req),
        .reg_rdata_o(rdata), .temp_mv_i(mv), .temp_open_i(temp_open_i),
        .fan_drive_o(drive));
    fpd_fan_model fan (.clk_i(clk_i), .clr_i(clr), .fan_drive_i(drive),
        .on_cyc_o(on_cyc));

    always #4 clk_i = ~clk_i;

    task automatic cmp(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        @(posedge clk_i);
        req <= '{wr: 1'b1, rd: 1'b0, sel: s, wdata: d};
        @(posedge clk_i);
        req.wr <= 1'b0;
    endtask

    task automatic rdchk(input logic [2:0] s, input logic [7:0] exp);
        @(posedge clk_i);
        req <= '{wr: 1'b0, rd: 1'b1, sel: s, wdata: 8'h00};
        @(posedge clk_i);
        req.rd <= 1'b0;
        #1;
        cmp($sformatf("register %0d", s), {8'h00, exp}, {8'h00, rdata});
    endtask

    task automatic meas(input int unsigned exp);
        repeat (2 * P) @(posedge clk_i);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        repeat (P) @(posedge clk_i);
        #1;
        cmp("on cycles", 16'(exp), on_cyc);
    endtask

    task automatic do_reset(input logic open);
        arst_n_i <= 1'b0;
        temp_open_i <= open;
        repeat (4) @(posedge clk_i);
        arst_n_i <= 1'b1;
    endtask

    task automatic t_regs();
        do_reset(1'b1);
        rdchk(SEL_DUTY, 8'h02);
        rdchk(SEL_CONFIG, 8'h00);
        rdchk(SEL_STATUS, 8'h04);
        rdchk(SEL_MAKER, 8'hA5);
        rdchk(SEL_VARIANT, 8'h03);
        wr(SEL_MAKER, 8'h5A);
        wr(SEL_VARIANT, 8'h00);
        rdchk(SEL_MAKER, 8'hA5);
        rdchk(SEL_VARIANT, 8'h03);
        rdchk(3'h0, 8'h00);
        rdchk(3'h7, 8'h00);
        @(posedge clk_i);
        mv <= 12'(2600);
        meas(11);
        $display("register and open fallback test done");
    endtask

    task automatic t_codes();
        wr(SEL_CONFIG, 8'h20);
        for (int c = 0; c < 16; c++)
        begin
            wr(SEL_DUTY, 8'(c));
            rdchk(SEL_DUTY, 8'(c));
            meas(P * (90 + 14 * c) / 300);
        end
        $display("register duty code test done");
    endtask

    task automatic t_temp();
        int unsigned m;
        @(posedge clk_i);
        do_reset(1'b0);
        rdchk(SEL_STATUS, 8'h00);
        foreach (mvs[i])
        begin
            m = mvs[i] < VIN_LO_MV ? VIN_LO_MV : mvs[i];
            m = m > VIN_HI_MV ? VIN_HI_MV : m;
            @(posedge clk_i);
            mv <= 12'(mvs[i]);
            meas(P * (2940 + 7 * (m - VIN_LO_MV)) / 9800);
        end
        // Input still far above the window: register mode must win.
        wr(SEL_CONFIG, 8'h20);
        rdchk(SEL_CONFIG, 8'h20);
        wr(SEL_DUTY, 8'h00);
        meas(P * 90 / 300);
        $display("temperature input test done");
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
        begin
            $display("Run complete: PASS");
        end
        else
        begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial
    begin
        repeat (100000) @(posedge clk_i);
        errors++;
        final_report();
    end

    initial
    begin
        clk_i = 1'b0;
        arst_n_i = 1'b0;
        temp_open_i = 1'b1;
        clr = 1'b0;
        req = '0;
        mv = 12'h000;
        errors = 0;
        n_checks = 0;
        t_regs();
        t_codes();
        t_temp();
        final_report();
    end
endmodule // tb_fpd_fan_duty
